// ### src/anl_exec.sv
// Combinational execute stage for one accumulator instruction pass.
// Assumes its caller registers the result and supplies the selected aux value.
module anl_exec (
  // Instruction and state in
  input  wire anl_pkg::anl_instr_s  instr,
  input  wire logic [31:0]          acc,
  input  wire logic [15:0]          aux,
  // Result out
  output anl_pkg::anl_result_s      res
);

  // Normalize test: bits 31 and 30 differ when already aligned
  wire         aligned   = acc[31] ^ acc[30];
  wire         is_zero   = (acc == 32'h0000_0000);
  wire         do_shift  = !is_zero && !aligned;
  // Aux step: default and explicit increment both add one
  wire  [15:0] aux_step  = (instr.modify == anl_pkg::MOD_DEC) ? aux - 16'h0001 :
                           (instr.modify == anl_pkg::MOD_NONE) ? aux : aux + 16'h0001;
  // Negation with wrap detection
  wire  [31:0] neg_val   = 32'h0000_0000 - acc;
  wire         neg_wrap  = (acc == anl_pkg::ACC_MOST_NEG);
  // Immediate shifted into a 31-bit field; bit 31 is never touched
  wire  [30:0] imm_wide  = 31'(({15'h0000, instr.operand}) << instr.shift);

  // Select the result per opcode
  always_comb begin
    res          = '0;
    res.acc      = acc;
    res.aux      = aux;
    unique case (instr.op)
      anl_pkg::OP_NEGATE: begin
        res.carry_we = 1'b1;
        res.carry    = is_zero;
        res.wrap     = neg_wrap;
        res.acc      = (neg_wrap && instr.clamp) ? anl_pkg::ACC_MOST_POS : neg_val;
      end
      anl_pkg::OP_ALIGN: begin
        res.test_we = 1'b1;
        if (do_shift) begin
          // Shift and count exponent
          res.acc    = {acc[30:0], 1'b0};
          res.aux    = aux_step;
          res.aux_we = 1'b1;
          res.test   = 1'b0;
        end else begin
          // Done: accumulator and aux hold, test flag set
          res.test   = 1'b1;
        end
      end
      anl_pkg::OP_ORMEM: begin
        // Upper half kept, sign mode ignored
        res.acc = {acc[31:16], acc[15:0] | instr.operand};
      end
      anl_pkg::OP_ORIMM: begin
        res.acc = {acc[31], acc[30:0] | imm_wide};
      end
      default: begin
        // Idle and port write leave the accumulator alone
        res.acc = acc;
      end
    endcase
  end

endmodule

// ### src/anl_pkg.sv
// Package for the accumulator normalize block: register map, fields, opcodes.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package anl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00; // Opcode, shift, aux modify, port, repeat, go
  localparam logic [7:0] OFF_OPERAND  = 8'h04; // Memory word / immediate
  localparam logic [7:0] OFF_ACC      = 8'h08; // Accumulator, read/write
  localparam logic [7:0] OFF_AUX_BASE = 8'h10; // Aux regs 0..7 at 0x10..0x2c
  localparam logic [7:0] OFF_STATUS   = 8'h30; // Flags, modes, busy
  localparam logic [7:0] OFF_PORT     = 8'h34; // Last port write: address and data

  // Control field positions
  localparam int CTRL_OP_LSB     = 0;  // 3-bit opcode
  localparam int CTRL_SHIFT_LSB  = 4;  // 4-bit immediate shift
  localparam int CTRL_MOD_LSB    = 8;  // 2-bit aux modification
  localparam int CTRL_PORT_LSB   = 12; // 4-bit port address
  localparam int CTRL_RPT_LSB    = 16; // 8-bit repeat count
  localparam int CTRL_GO_BIT     = 31; // Write 1 to start

  // Status field positions
  localparam int STAT_TEST_BIT   = 0;  // Test flag
  localparam int STAT_WRAP_BIT   = 1;  // Overflow, sticky
  localparam int STAT_CARRY_BIT  = 2;  // Carry
  localparam int STAT_CLAMP_BIT  = 3;  // Saturation mode, writable
  localparam int STAT_SXM_BIT    = 4;  // Sign extension mode, writable
  localparam int STAT_BUSY_BIT   = 8;  // Instruction in progress
  localparam int STAT_PTR_LSB    = 12; // 3-bit aux pointer, writable

  // Reset values
  localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
  localparam logic [15:0] AUX_RESET  = 16'h0000;

  // Saturation and special values
  localparam logic [31:0] ACC_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] ACC_MOST_POS = 32'h7fff_ffff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Instruction opcodes
  typedef enum logic [2:0] {
    OP_IDLE   = 3'b000, // Only the program counter would move
    OP_NEGATE = 3'b001, // Two's complement of accumulator
    OP_ALIGN  = 3'b010, // One normalize step per pass
    OP_ORMEM  = 3'b011, // OR memory word into low half
    OP_ORIMM  = 3'b100, // OR shifted immediate, bit 31 kept
    OP_PORTWR = 3'b101  // Send operand to an I/O port
  } anl_op_e;

  // Aux modification on a normalize step
  typedef enum logic [1:0] {
    MOD_DEFAULT = 2'b00, // Increment
    MOD_INC     = 2'b01,
    MOD_DEC     = 2'b10,
    MOD_NONE    = 2'b11
  } anl_mod_e;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } anl_state_e;

  // Decoded instruction handed to the datapath
  typedef struct packed {
    anl_op_e     op;
    logic [3:0]  shift;
    anl_mod_e    modify;
    logic [15:0] operand;
    logic        clamp;
  } anl_instr_s;

  // Datapath result
  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] aux;
    logic        aux_we;
    logic        test;
    logic        test_we;
    logic        wrap;
    logic        carry;
    logic        carry_we;
  } anl_result_s;

endpackage

// ### src/anl_top.sv
// Accumulator normalize logic: AXI4-Lite slave plus sequencer and datapath.
// Assumes one 100 MHz clock, an AXI4-Lite master, and software that owns aux setup.
//
// Local design decisions: register access over AXI4-Lite and the address map.
module anl_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Write address channel
  input  wire logic [7:0]  S_AWADDR,
  input  wire logic        S_AWVALID,
  output logic             S_AWREADY,
  // Write data channel
  input  wire logic [31:0] S_WDATA,
  input  wire logic [3:0]  S_WSTRB,
  input  wire logic        S_WVALID,
  output logic             S_WREADY,
  // Write response channel
  output logic [1:0]       S_BRESP,
  output logic             S_BVALID,
  input  wire logic        S_BREADY,
  // Read address channel
  input  wire logic [7:0]  S_ARADDR,
  input  wire logic        S_ARVALID,
  output logic             S_ARREADY,
  // Read data channel
  output logic [31:0]      S_RDATA,
  output logic [1:0]       S_RRESP,
  output logic             S_RVALID,
  input  wire logic        S_RREADY,
  // I/O port output
  output logic [3:0]       PORT_ADDR,
  output logic [15:0]      PORT_DATA,
  output logic             PORT_STROBE
);

  // Architectural state
  logic [31:0]          acc;          // Accumulator
  logic [15:0]          aux [8];      // Auxiliary registers
  logic [2:0]           aux_pointer;  // Selects the active aux register
  logic                 test_flag;    // Normalize result flag
  logic                 arith_wrap_flag; // Sticky overflow
  logic                 carry;        // Carry bit
  logic                 clamp_mode;   // Saturate on overflow
  logic                 sign_extension_mode; // Stored only; no op here uses it
  logic [31:0]          ctrl;         // Last instruction written
  logic [15:0]          operand;      // Operand word
  anl_pkg::anl_state_e  state;        // Sequencer state
  logic [7:0]           passes_left;  // Remaining repeat passes

  // Write channel capture, address and data may come in either order
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;

  // Byte-lane merge of a write with an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Handshake decode
  wire aw_take   = S_AWVALID && S_AWREADY;
  wire w_take    = S_WVALID && S_WREADY;
  wire ar_take   = S_ARVALID && S_ARREADY;
  wire wr_fire   = aw_held && w_held && !S_BVALID;
  wire busy      = (state == anl_pkg::ST_RUN);

  // Write address decode
  wire        wa_ctrl   = (aw_addr == anl_pkg::OFF_CTRL);
  wire        wa_oper   = (aw_addr == anl_pkg::OFF_OPERAND);
  wire        wa_acc    = (aw_addr == anl_pkg::OFF_ACC);
  wire        wa_stat   = (aw_addr == anl_pkg::OFF_STATUS);
  wire        wa_aux    = (aw_addr >= anl_pkg::OFF_AUX_BASE) &&
                          (aw_addr < anl_pkg::OFF_STATUS) && (aw_addr[1:0] == 2'b00);
  wire [7:0]  wa_aoff   = aw_addr - anl_pkg::OFF_AUX_BASE;
  wire [2:0]  wa_aidx   = wa_aoff[4:2];
  wire        wa_port   = (aw_addr == anl_pkg::OFF_PORT);
  wire        wa_ok     = wa_ctrl || wa_oper || wa_acc || wa_stat || wa_aux || wa_port;
  wire [31:0] ctrl_new  = merge(ctrl, w_data, w_strb);
  // Start only when idle; a go while busy is ignored
  wire        go        = wr_fire && wa_ctrl && ctrl_new[anl_pkg::CTRL_GO_BIT] && !busy;

  // Status word seen by software
  wire [31:0] status_word = {16'h0000, 1'b0, aux_pointer, 3'b000, busy, 3'b000,
                             sign_extension_mode, clamp_mode, carry, arith_wrap_flag,
                             test_flag};
  wire [31:0] stat_new  = merge(status_word, w_data, w_strb);
  // Merged operand and aux words; a function result cannot be sliced directly
  wire [31:0] oper_new  = merge({16'h0000, operand}, w_data, w_strb);
  wire [31:0] aux_new   = merge({16'h0000, aux[wa_aidx]}, w_data, w_strb);

  // Read address decode
  wire        ra_aux    = (S_ARADDR >= anl_pkg::OFF_AUX_BASE) &&
                          (S_ARADDR < anl_pkg::OFF_STATUS) && (S_ARADDR[1:0] == 2'b00);
  wire [7:0]  ra_aoff   = S_ARADDR - anl_pkg::OFF_AUX_BASE;
  wire [2:0]  ra_aidx   = ra_aoff[4:2];
  wire        ra_ok     = ra_aux || (S_ARADDR == anl_pkg::OFF_CTRL) ||
                          (S_ARADDR == anl_pkg::OFF_OPERAND) ||
                          (S_ARADDR == anl_pkg::OFF_ACC) ||
                          (S_ARADDR == anl_pkg::OFF_STATUS) ||
                          (S_ARADDR == anl_pkg::OFF_PORT);
  wire [31:0] rd_mux    = ra_aux                           ? {16'h0000, aux[ra_aidx]} :
                          (S_ARADDR == anl_pkg::OFF_CTRL)    ? ctrl :
                          (S_ARADDR == anl_pkg::OFF_OPERAND) ? {16'h0000, operand} :
                          (S_ARADDR == anl_pkg::OFF_ACC)     ? acc :
                          (S_ARADDR == anl_pkg::OFF_STATUS)  ? status_word :
                          (S_ARADDR == anl_pkg::OFF_PORT)    ? {12'h000, PORT_ADDR, PORT_DATA} :
                          32'h0000_0000;

  // Decoded instruction from the held control word
  anl_pkg::anl_instr_s  instr;
  anl_pkg::anl_result_s res;
  assign instr.op      = anl_pkg::anl_op_e'(ctrl[anl_pkg::CTRL_OP_LSB +: 3]);
  assign instr.shift   = ctrl[anl_pkg::CTRL_SHIFT_LSB +: 4];
  assign instr.modify  = anl_pkg::anl_mod_e'(ctrl[anl_pkg::CTRL_MOD_LSB +: 2]);
  assign instr.operand = operand;
  assign instr.clamp   = clamp_mode;

  // Datapath for one pass
  anl_exec i_anl_exec (
    .instr (instr),
    .acc   (acc),
    .aux   (aux[aux_pointer]),
    .res   (res)
  );

  // Pass strobe; the last pass returns to idle
  wire step      = busy;
  wire last_pass = (passes_left == 8'h00);
  wire next_idle = step && last_pass;

  // AXI write address and data acceptance
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
    end else begin
      S_AWREADY <= !aw_held && !aw_take;
      S_WREADY  <= !w_held && !w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= S_AWADDR;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= S_WDATA;
        w_strb <= S_WSTRB;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // AXI write response
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_BVALID <= 1'b0;
      S_BRESP  <= anl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_BVALID <= 1'b1;
      S_BRESP  <= wa_ok ? anl_pkg::RESP_OKAY : anl_pkg::RESP_SLVERR;
    end else if (S_BREADY) begin
      S_BVALID <= 1'b0;
    end
  end

  // AXI read channel, one read in flight
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RDATA   <= 32'h0000_0000;
      S_RRESP   <= anl_pkg::RESP_OKAY;
    end else begin
      S_ARREADY <= !S_RVALID && !ar_take;
      if (ar_take) begin
        S_RVALID <= 1'b1;
        S_RDATA  <= rd_mux;
        S_RRESP  <= ra_ok ? anl_pkg::RESP_OKAY : anl_pkg::RESP_SLVERR;
      end else if (S_RREADY) begin
        S_RVALID <= 1'b0;
      end
    end
  end

  // Control and operand registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl    <= 32'h0000_0000;
      operand <= 16'h0000;
    end else begin
      // Control is frozen while an instruction runs
      if (wr_fire && wa_ctrl && !busy) begin
        ctrl <= {1'b0, ctrl_new[30:0]};
      end
      if (wr_fire && wa_oper && !busy) begin
        operand <= oper_new[15:0];
      end
    end
  end

  // Sequencer: one pass per cycle, every repeat pass executes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state       <= anl_pkg::ST_IDLE;
      passes_left <= 8'h00;
    end else if (go) begin
      state       <= anl_pkg::ST_RUN;
      passes_left <= ctrl_new[anl_pkg::CTRL_RPT_LSB +: 8];
    end else if (next_idle) begin
      state       <= anl_pkg::ST_IDLE;
    end else if (step) begin
      passes_left <= passes_left - 8'h01;
    end
  end

  // Accumulator: datapath pass or software write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc <= anl_pkg::ACC_RESET;
    end else if (step) begin
      acc <= res.acc;
    end else if (wr_fire && wa_acc) begin
      acc <= merge(acc, w_data, w_strb);
    end
  end

  // Aux registers; a datapath step wins over a software write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) begin
        aux[i] <= anl_pkg::AUX_RESET;
      end
    end else if (step && res.aux_we) begin
      aux[aux_pointer] <= res.aux;
    end else if (wr_fire && wa_aux) begin
      aux[wa_aidx] <= aux_new[15:0];
    end
  end

  // Status flags; hardware set wins over a software clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_flag           <= 1'b0;
      arith_wrap_flag     <= 1'b0;
      carry               <= 1'b0;
      clamp_mode          <= 1'b0;
      sign_extension_mode <= 1'b1;
      aux_pointer         <= 3'b000;
    end else begin
      if (wr_fire && wa_stat) begin
        test_flag           <= stat_new[anl_pkg::STAT_TEST_BIT];
        arith_wrap_flag     <= stat_new[anl_pkg::STAT_WRAP_BIT];
        carry               <= stat_new[anl_pkg::STAT_CARRY_BIT];
        clamp_mode          <= stat_new[anl_pkg::STAT_CLAMP_BIT];
        sign_extension_mode <= stat_new[anl_pkg::STAT_SXM_BIT];
        if (!busy) begin
          aux_pointer <= stat_new[anl_pkg::STAT_PTR_LSB +: 3];
        end
      end
      if (step && res.test_we) begin
        test_flag <= res.test;
      end
      if (step && res.carry_we) begin
        carry <= res.carry;
      end
      if (step && res.wrap) begin
        arith_wrap_flag <= 1'b1;
      end
    end
  end

  // Port write: one strobe per pass, idle op drives nothing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_ADDR   <= 4'h0;
      PORT_DATA   <= 16'h0000;
      PORT_STROBE <= 1'b0;
    end else begin
      PORT_STROBE <= step && (instr.op == anl_pkg::OP_PORTWR);
      if (step && (instr.op == anl_pkg::OP_PORTWR)) begin
        PORT_ADDR <= ctrl[anl_pkg::CTRL_PORT_LSB +: 4];
        PORT_DATA <= operand;
      end
    end
  end

endmodule

// ### tb/anl_tb_top.sv
// Self-checking bench for the accumulator normalize block.
// Assumes anl_top is reached only over its AXI4-Lite slave.
module anl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0;           // Clock and reset
  logic [7:0]  awaddr = 0, araddr = 0;       // Addresses
  logic        awvalid = 0, wvalid = 0, arvalid = 0;
  logic        bready = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic        awready, wready, bvalid, arready, rvalid, strobe;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  p_addr;
  logic [15:0] p_data;
  int          err_count = 0, checked = 0, strobes = 0;

  anl_top i_anl_top (.CLK(clk), .RST_N(rst_n), .S_AWADDR(awaddr), .S_AWVALID(awvalid),
    .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(4'hf), .S_WVALID(wvalid),
    .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
    .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
    .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .PORT_ADDR(p_addr),
    .PORT_DATA(p_data), .PORT_STROBE(strobe));

  initial forever #5 clk = ~clk;
  // Count strobe pulses so a doubled pulse is seen
  always @(posedge clk) if (strobe === 1'b1) strobes++;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A spent bound counts as a mismatch and closes the run
  task automatic tmo(input int n);
    if (n >= 60) begin
      err_count++;
      $display("mismatch handshake_wait expected below 60 seen %0d", n);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    aw = 1; w = 1;
    for (n = 0; n < 60 && (aw || w); n++) begin
      @(posedge clk);
      if (aw && awready) begin awvalid <= 0; aw = 0; end
      if (w && wready) begin wvalid <= 0; w = 0; end
    end
    tmo(n);
    for (n = 0; n < 60 && bvalid !== 1'b1; n++) @(posedge clk);
    tmo(n);
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arready) break;
    end
    tmo(n);
    arvalid <= 0;
    for (n = 0; n < 60 && rvalid !== 1'b1; n++) @(posedge clk);
    tmo(n);
    d = rdata; r = rresp;
    rready <= 0;
  endtask

  // Checked write and read of mapped registers
  task automatic w32(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(anl_pkg::RESP_OKAY), 32'(r));
  endtask
  task automatic r_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask

  // Control word: go, repeat, port, modify, shift, opcode
  function automatic logic [31:0] cw(input logic [2:0] op, input logic [3:0] sh,
      input logic [1:0] md, input logic [3:0] pt, input logic [7:0] rp);
    return {1'b1, 7'h00, rp, pt, 2'b00, md, sh, 1'b0, op};
  endfunction

  // Start an instruction and poll busy with a bound
  task automatic run(input logic [31:0] c);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    w32(anl_pkg::OFF_CTRL, c);
    for (n = 0; n < 60; n++) begin
      rd(anl_pkg::OFF_STATUS, s, r);
      if (s[anl_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    tmo(n);
  endtask

  // Pointer, clamp mode (sign extension kept on), then accumulator
  task automatic setup(input logic [31:0] acc, input logic [2:0] p, input logic cl);
    w32(anl_pkg::OFF_STATUS, 32'h0000_0010 | ({29'h0, p} << 12) | ({31'h0, cl} << 3));
    w32(anl_pkg::OFF_ACC, acc);
  endtask

  // Full normalize under a long repeat, default modify, spare passes set the test flag
  task automatic t_mantissa_align_step_full;
    setup(32'h0000_0001, 3'h1, 1'b0);
    w32(8'h14, 32'h0000_0000);
    run(cw(anl_pkg::OP_ALIGN, 4'h0, anl_pkg::MOD_DEFAULT, 4'h0, 8'h1f));
    r_chk("acc", anl_pkg::OFF_ACC, 32'h4000_0000);
    r_chk("aux1", 8'h14, 32'h0000_001e);
    r_chk("status", anl_pkg::OFF_STATUS, 32'h0000_1011);
    $display("test mantissa_align_step_full done");
  endtask

  // One shifting step then a bounded repeat, decrementing modify
  task automatic t_mantissa_align_step_bounded;
    setup(32'h0100_0000, 3'h2, 1'b0);
    w32(8'h18, 32'h0000_000f);
    run(cw(anl_pkg::OP_ALIGN, 4'h0, anl_pkg::MOD_DEC, 4'h0, 8'h00));
    r_chk("acc", anl_pkg::OFF_ACC, 32'h0200_0000);
    r_chk("status", anl_pkg::OFF_STATUS, 32'h0000_2010);
    run(cw(anl_pkg::OP_ALIGN, 4'h0, anl_pkg::MOD_DEC, 4'h0, 8'h0e));
    r_chk("acc", anl_pkg::OFF_ACC, 32'h4000_0000);
    r_chk("aux2", 8'h18, 32'h0000_0009);
    // Explicit increment, then a step that leaves the aux register alone
    setup(32'h1000_0000, 3'h3, 1'b0);
    w32(8'h1c, 32'h0000_0005);
    run(cw(anl_pkg::OP_ALIGN, 4'h0, anl_pkg::MOD_INC, 4'h0, 8'h00));
    run(cw(anl_pkg::OP_ALIGN, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("acc3", anl_pkg::OFF_ACC, 32'h4000_0000);
    r_chk("aux3", 8'h1c, 32'h0000_0006);
    $display("test mantissa_align_step_bounded done");
  endtask

  // Combines, negate with clamp, idle op, port write, unmapped place
  task automatic t_misc;
    logic [31:0] d;
    logic [1:0] r;
    setup(32'h8000_0000, 3'h0, 1'b0);
    w32(anl_pkg::OFF_OPERAND, 32'h0000_ffff);
    run(cw(anl_pkg::OP_ORIMM, 4'hf, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("orimm", anl_pkg::OFF_ACC, 32'hffff_8000);
    setup(32'h0000_0000, 3'h0, 1'b0);
    run(cw(anl_pkg::OP_ORIMM, 4'hf, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("orimm0", anl_pkg::OFF_ACC, 32'h7fff_8000);
    setup(32'h1234_0001, 3'h0, 1'b0);
    w32(anl_pkg::OFF_OPERAND, 32'h0000_f000);
    run(cw(anl_pkg::OP_ORMEM, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("ormem", anl_pkg::OFF_ACC, 32'h1234_f001);
    run(cw(anl_pkg::OP_IDLE, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("idle", anl_pkg::OFF_ACC, 32'h1234_f001);
    setup(32'h0000_0005, 3'h0, 1'b0);
    run(cw(anl_pkg::OP_NEGATE, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("neg", anl_pkg::OFF_ACC, 32'hffff_fffb);
    setup(32'h0000_0000, 3'h0, 1'b0);
    run(cw(anl_pkg::OP_NEGATE, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    rd(anl_pkg::OFF_STATUS, d, r);
    chk("carry", 32'h1, {31'h0, d[anl_pkg::STAT_CARRY_BIT]});
    setup(anl_pkg::ACC_MOST_NEG, 3'h0, 1'b1);
    run(cw(anl_pkg::OP_NEGATE, 4'h0, anl_pkg::MOD_NONE, 4'h0, 8'h00));
    r_chk("negsat", anl_pkg::OFF_ACC, anl_pkg::ACC_MOST_POS);
    rd(anl_pkg::OFF_STATUS, d, r);
    chk("wrap", 32'h1, {31'h0, d[anl_pkg::STAT_WRAP_BIT]});
    strobes = 0;
    w32(anl_pkg::OFF_OPERAND, 32'h0000_beef);
    run(cw(anl_pkg::OP_PORTWR, 4'h0, anl_pkg::MOD_NONE, 4'h9, 8'h00));
    chk("strobes", 32'h1, 32'(strobes));
    chk("port", 32'h0009_beef, {12'h000, p_addr, p_data});
    r_chk("portreg", anl_pkg::OFF_PORT, 32'h0009_beef);
    rd(8'h3c, d, r);
    chk("rresp", 32'(anl_pkg::RESP_SLVERR), 32'(r));
    wr(8'h3c, 32'h1, r);
    chk("bresp", 32'(anl_pkg::RESP_SLVERR), 32'(r));
    $display("test misc done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    t_mantissa_align_step_full();
    t_mantissa_align_step_bounded();
    t_misc();
    end_of_test();
  end
endmodule

// ### tb/anl_top_asserts.sv
// Bus and port-output checker for the accumulator normalize block.
// Assumes it is bound to anl_top and sees only its ports.
module anl_top_asserts (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Write channels
  input wire logic        S_AWVALID,
  input wire logic        S_AWREADY,
  input wire logic        S_WVALID,
  input wire logic        S_WREADY,
  input wire logic [1:0]  S_BRESP,
  input wire logic        S_BVALID,
  input wire logic        S_BREADY,
  // Read channels
  input wire logic        S_ARVALID,
  input wire logic        S_ARREADY,
  input wire logic [31:0] S_RDATA,
  input wire logic        S_RVALID,
  input wire logic        S_RREADY,
  // Port output
  input wire logic [3:0]  PORT_ADDR,
  input wire logic [15:0] PORT_DATA,
  input wire logic        PORT_STROBE
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  AST_BVALID_HOLD: assert property (S_BVALID && !S_BREADY |=> S_BVALID && $stable(S_BRESP))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
    else $error("read data dropped early");
  AST_WRITE_ANSWER: assert property (S_AWVALID && S_AWREADY && S_WVALID && S_WREADY
    |-> ##[1:2] S_BVALID) else $error("write response late");
  AST_READ_ANSWER: assert property (S_ARVALID && S_ARREADY |=> S_RVALID)
    else $error("read data late");
  AST_AR_BLOCKED: assert property (S_RVALID |-> !S_ARREADY)
    else $error("read address taken while data pending");
  AST_B_RELEASE: assert property (S_BVALID && S_BREADY |=> !S_BVALID)
    else $error("write response repeated");
  AST_RESP_LEGAL: assert property (S_BVALID |-> S_BRESP == anl_pkg::RESP_OKAY
    || S_BRESP == anl_pkg::RESP_SLVERR) else $error("illegal write response");
  // Port lines only move together with the strobe
  AST_PORT_QUIET: assert property (!PORT_STROBE |-> $stable(PORT_ADDR) && $stable(PORT_DATA))
    else $error("port lines moved without strobe");

  COV_WRITE: cover property (S_BVALID && S_BREADY);
  COV_READ: cover property (S_RVALID && S_RREADY);
  COV_PORT: cover property (PORT_STROBE);
endmodule

bind anl_top anl_top_asserts i_anl_top_asserts (
  .CLK(CLK), .RST_N(RST_N), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY),
  .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BRESP(S_BRESP), .S_BVALID(S_BVALID),
  .S_BREADY(S_BREADY), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA),
  .S_RVALID(S_RVALID), .S_RREADY(S_RREADY), .PORT_ADDR(PORT_ADDR),
  .PORT_DATA(PORT_DATA), .PORT_STROBE(PORT_STROBE));
